// [hw/ctp_pkg.sv]
package ctp_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_LOWER_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_UPPER_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_LOWER_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_UPPER_PERIOD = 8'h0C;
    localparam logic [7:0] ADDR_LOWER_COUNT  = 8'h10;
    localparam logic [7:0] ADDR_UPPER_COUNT  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_PRIO     = 8'h20;
    // control field positions
    localparam int CTRL_TIMER_ON   = 15;
    localparam int CTRL_IDLE_STOP  = 13;
    localparam int CTRL_GATE       = 6;
    localparam int CTRL_PRE_HI     = 5;
    localparam int CTRL_PRE_LO     = 4;
    localparam int CTRL_CASCADE    = 3;
    localparam int CTRL_CLK_SRC    = 1;
    localparam logic [15:0] CTRL_WMASK = 16'hA07A;
    // status and mask bit positions
    localparam int IRQ_LOWER = 0;
    localparam int IRQ_UPPER = 1;
    // reset values
    localparam logic [15:0] RST_CTRL   = 16'h0000;
    localparam logic [15:0] RST_PERIOD = 16'hFFFF;
    localparam logic [15:0] RST_COUNT  = 16'h0000;
    localparam logic [1:0]  AXI_OKAY   = 2'b00;
    localparam logic [1:0]  AXI_SLVERR = 2'b10;
    // prescale ratios 1, 8, 64, 256 as counter terminal values
    localparam logic [7:0] PRE_TERM_1   = 8'h00;
    localparam logic [7:0] PRE_TERM_8   = 8'h07;
    localparam logic [7:0] PRE_TERM_64  = 8'h3F;
    localparam logic [7:0] PRE_TERM_256 = 8'hFF;
endpackage

// [hw/ctp_timer16.sv]
`timescale 1ns/10ps
`default_nettype none
module ctp_timer16
    import ctp_pkg::*;
(
    // clocking
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // configuration
    input  wire logic        run,
    input  wire logic [1:0]  prescale_select,
    input  wire logic        clock_source_select,
    input  wire logic        gate_enable,
    // inputs (already synchronised)
    input  wire logic        ext_rise,
    input  wire logic        gate_level,
    // held clear while the timer on bit is low
    input  wire logic        pre_clear,
    // prescaled tick out
    output logic             tick
);
    logic [7:0] pre_cnt;
    logic [7:0] term;
    logic       src;

    // prescale ratio decode
    always_comb begin
        case (prescale_select)
            2'b00:   term = PRE_TERM_1;
            2'b01:   term = PRE_TERM_8;
            2'b10:   term = PRE_TERM_64;
            default: term = PRE_TERM_256;
        endcase
    end

    // gated mode counts internal clock only while gate is high
    assign src = clock_source_select ? ext_rise
               : (gate_enable ? gate_level : 1'b1);
    assign tick = run && src && (pre_cnt == term);

    // prescaler counter; the clear waits for ce too, so a frozen block holds every bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt <= 8'h00;
        end else if (ce) begin
            if (pre_clear) begin
                pre_cnt <= 8'h00;
            end else if (run && src) begin
                pre_cnt <= (pre_cnt == term) ? 8'h00 : pre_cnt + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// [hw/ctp_timer_pair.sv]
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module ctp_timer_pair
    import ctp_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // power state
    input  wire logic        idle_mode,
    // external pins
    input  wire logic        lower_clk_pin,
    input  wire logic        upper_clk_pin,
    input  wire logic        lower_gate_pin,
    input  wire logic        upper_gate_pin,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // system outputs
    output logic             irq,
    output logic [2:0]       irq_priority,
    output logic             adc_trigger,
    output logic [15:0]      lower_time_base,
    output logic [15:0]      upper_time_base
);
    logic [15:0] lower_timer_control;
    logic [15:0] upper_timer_control;
    logic [15:0] lower_period;
    logic [15:0] upper_period;
    logic [15:0] lower_count;
    logic [15:0] upper_count;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [2:0]  timer_irq_priority;
    logic [2:0]  upper_irq_priority;
    logic [3:0]  pin_s1;
    logic [3:0]  pin_s2;
    logic [1:0]  clk_last;
    logic        cascade_enable;
    logic        lower_run;
    logic        upper_run;
    logic        lower_tick;
    logic        upper_tick;
    logic        lower_match;
    logic        upper_match;
    logic        wide_match;
    logic        lower_ev;
    logic        upper_ev;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_go;
    logic        wr_hit;
    logic [31:0] rd_val;
    logic        rd_hit;

    // running state; idle stop only honoured, sleep never stops the count
    function automatic logic ctp_runs(input logic [15:0] ctrl, input logic idle);
        ctp_runs = ctrl[CTRL_TIMER_ON] && !(idle && ctrl[CTRL_IDLE_STOP]);
    endfunction

    // merge a 16-bit register with strobed write data
    function automatic logic [15:0] ctp_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
        ctp_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    assign cascade_enable = lower_timer_control[CTRL_CASCADE];
    assign lower_run = ctp_runs(lower_timer_control, idle_mode);
    // upper control ignored when cascaded
    assign upper_run = !cascade_enable && ctp_runs(upper_timer_control, idle_mode);

    // two-stage pin synchronisers; asynchronous counting is not offered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1   <= 4'h0;
            pin_s2   <= 4'h0;
            clk_last <= 2'b00;
        end else if (ce) begin
            pin_s1   <= {upper_gate_pin, lower_gate_pin, upper_clk_pin, lower_clk_pin};
            pin_s2   <= pin_s1;
            clk_last <= pin_s2[1:0];
        end
    end

    // lower prescaler also drives the cascaded pair
    ctp_timer16 u_lower (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .ce                  (ce),
        .run                 (lower_run),
        .prescale_select     (lower_timer_control[CTRL_PRE_HI:CTRL_PRE_LO]),
        .clock_source_select (lower_timer_control[CTRL_CLK_SRC]),
        .gate_enable         (lower_timer_control[CTRL_GATE]),
        .ext_rise            (pin_s2[0] && !clk_last[0]),
        .gate_level          (pin_s2[2]),
        .pre_clear           (!lower_timer_control[CTRL_TIMER_ON]),
        .tick                (lower_tick)
    );

    ctp_timer16 u_upper (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .ce                  (ce),
        .run                 (upper_run),
        .prescale_select     (upper_timer_control[CTRL_PRE_HI:CTRL_PRE_LO]),
        .clock_source_select (upper_timer_control[CTRL_CLK_SRC]),
        .gate_enable         (upper_timer_control[CTRL_GATE]),
        .ext_rise            (pin_s2[1] && !clk_last[1]),
        .gate_level          (pin_s2[3]),
        .pre_clear           (!upper_timer_control[CTRL_TIMER_ON]),
        .tick                (upper_tick)
    );

    // match decode
    assign lower_match = (lower_count == lower_period);
    assign upper_match = (upper_count == upper_period);
    assign wide_match  = ({upper_count, lower_count} == {upper_period, lower_period});
    assign lower_ev = cascade_enable ? 1'b0 : (lower_tick && lower_match);
    assign upper_ev = cascade_enable ? (lower_tick && wide_match) : (upper_tick && upper_match);

    // axi write capture: address and data in either order
    // ready held low while frozen, else a beat would be taken and lost
    assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    assign wr_hit = (aw_addr == ADDR_LOWER_CTRL) || (aw_addr == ADDR_UPPER_CTRL)
                 || (aw_addr == ADDR_LOWER_PERIOD) || (aw_addr == ADDR_UPPER_PERIOD)
                 || (aw_addr == ADDR_LOWER_COUNT) || (aw_addr == ADDR_UPPER_COUNT)
                 || (aw_addr == ADDR_IRQ_STATUS) || (aw_addr == ADDR_IRQ_MASK)
                 || (aw_addr == ADDR_IRQ_PRIO);

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // configuration registers; software keeps the set-up order itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lower_timer_control <= RST_CTRL;
            upper_timer_control <= RST_CTRL;
            lower_period        <= RST_PERIOD;
            upper_period        <= RST_PERIOD;
            irq_mask            <= 2'b00;
            timer_irq_priority  <= 3'h0;
            upper_irq_priority  <= 3'h0;
        end else if (ce && wr_go) begin
            if (aw_addr == ADDR_LOWER_CTRL) begin
                lower_timer_control <= ctp_merge(lower_timer_control, w_data, w_strb) & CTRL_WMASK;
            end else if (aw_addr == ADDR_UPPER_CTRL) begin
                upper_timer_control <= ctp_merge(upper_timer_control, w_data, w_strb) & CTRL_WMASK;
            end else if (aw_addr == ADDR_LOWER_PERIOD) begin
                lower_period <= ctp_merge(lower_period, w_data, w_strb);
            end else if (aw_addr == ADDR_UPPER_PERIOD) begin
                upper_period <= ctp_merge(upper_period, w_data, w_strb);
            end else if (aw_addr == ADDR_IRQ_MASK && w_strb[0]) begin
                irq_mask <= w_data[1:0];
            end else if (aw_addr == ADDR_IRQ_PRIO && w_strb[0]) begin
                timer_irq_priority <= w_data[2:0];
                upper_irq_priority <= w_data[6:4];
            end
        end
    end

    // lower count: wraps to zero on the tick after match
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lower_count <= RST_COUNT;
        end else if (ce) begin
            if (wr_go && aw_addr == ADDR_LOWER_COUNT) begin
                lower_count <= ctp_merge(lower_count, w_data, w_strb);
            end else if (lower_tick) begin
                if (cascade_enable ? wide_match : lower_match) begin
                    lower_count <= RST_COUNT;
                end else begin
                    lower_count <= lower_count + 16'h0001;
                end
            end
        end
    end

    // upper count: carries from lower when cascaded, else its own tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upper_count <= RST_COUNT;
        end else if (ce) begin
            if (wr_go && aw_addr == ADDR_UPPER_COUNT) begin
                upper_count <= ctp_merge(upper_count, w_data, w_strb);
            end else if (cascade_enable && lower_tick) begin
                if (wide_match) begin
                    upper_count <= RST_COUNT;
                end else if (lower_count == 16'hFFFF) begin
                    upper_count <= upper_count + 16'h0001;
                end
            end else if (!cascade_enable && upper_tick) begin
                upper_count <= upper_match ? RST_COUNT : upper_count + 16'h0001;
            end
        end
    end

    // sticky flags; a new event beats a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 2'b00;
        end else if (ce) begin
            for (int i = 0; i < 2; i++) begin
                if ((i == IRQ_LOWER) ? lower_ev : upper_ev) begin
                    irq_status[i] <= 1'b1;
                end else if (wr_go && aw_addr == ADDR_IRQ_STATUS && w_strb[0] && w_data[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
        end
    end

    // single level interrupt; priority follows the winning source
    assign irq = |(irq_status & irq_mask);
    assign irq_priority = (irq_status[IRQ_UPPER] && irq_mask[IRQ_UPPER]) ? upper_irq_priority
                        : timer_irq_priority;

    // adc trigger registered; only the cascaded pair drives it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adc_trigger     <= 1'b0;
            lower_time_base <= RST_COUNT;
            upper_time_base <= RST_COUNT;
        end else if (ce) begin
            adc_trigger     <= cascade_enable && upper_ev;
            lower_time_base <= lower_count;
            upper_time_base <= upper_count;
        end
    end

    // read decode
    always_comb begin
        rd_hit = 1'b1;
        if (s_axi_araddr == ADDR_LOWER_CTRL) begin
            rd_val = {16'h0000, lower_timer_control};
        end else if (s_axi_araddr == ADDR_UPPER_CTRL) begin
            rd_val = {16'h0000, upper_timer_control};
        end else if (s_axi_araddr == ADDR_LOWER_PERIOD) begin
            rd_val = {16'h0000, lower_period};
        end else if (s_axi_araddr == ADDR_UPPER_PERIOD) begin
            rd_val = {16'h0000, upper_period};
        end else if (s_axi_araddr == ADDR_LOWER_COUNT) begin
            rd_val = {16'h0000, lower_count};
        end else if (s_axi_araddr == ADDR_UPPER_COUNT) begin
            rd_val = {16'h0000, upper_count};
        end else if (s_axi_araddr == ADDR_IRQ_STATUS) begin
            rd_val = {30'h0000_0000, irq_status};
        end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
            rd_val = {30'h0000_0000, irq_mask};
        end else if (s_axi_araddr == ADDR_IRQ_PRIO) begin
            rd_val = {25'h000_0000, upper_irq_priority, 1'b0, timer_irq_priority};
        end else begin
            rd_val = 32'h0000_0000;
            rd_hit = 1'b0;
        end
    end

    // read channel: one outstanding read
    assign s_axi_arready = ce && !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= AXI_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/ctp_timer_pair_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module ctp_timer_pair_chk
    import ctp_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    // bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // system outputs
    input wire logic        irq,
    input wire logic        adc_trigger
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // both write channels taken on one edge
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
    endsequence
    // read of the first address past the map
    sequence s_rd_unmapped;
        s_axi_arvalid && s_axi_arready && ce && s_axi_araddr == 8'h24;
    endsequence

    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before rready");
    chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    chk_wr_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
        else $error("read data late");
    chk_rd_unmapped: assert property (s_rd_unmapped |=> s_axi_rvalid && s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_adc_pulse: assert property (adc_trigger |=> !adc_trigger)
        else $error("adc trigger longer than one cycle");
    // reset must quiet outputs even though the default disable is reset
    chk_reset_quiet: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && !adc_trigger)
        else $error("outputs active after reset");
endmodule

bind ctp_timer_pair ctp_timer_pair_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq(irq), .adc_trigger(adc_trigger));
`default_nettype wire

// [tb/test_ctp_timer_pair.sv]
`timescale 1ns/10ps
`default_nettype none
module test_ctp_timer_pair;
    import ctp_pkg::*;
    logic        aclk, aresetn, ce, idle_mode, lower_clk_pin, lower_gate_pin, carry;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, c0;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
    logic        irq, adc_trigger;
    logic [2:0]  irq_priority;
    logic [15:0] lower_time_base, upper_time_base;
    logic [7:0]  pre_t [4] = '{PRE_TERM_1, PRE_TERM_8, PRE_TERM_64, PRE_TERM_256};
    int          n_mismatch, n_compared, cyc, n_adc, n, i;

    // upper pins tied: cascade must ignore them anyway
    ctp_timer_pair DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .idle_mode(idle_mode),
        .lower_clk_pin(lower_clk_pin), .upper_clk_pin(1'b0), .lower_gate_pin(lower_gate_pin),
        .upper_gate_pin(1'b0), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .irq(irq), .irq_priority(irq_priority), .adc_trigger(adc_trigger),
        .lower_time_base(lower_time_base), .upper_time_base(upper_time_base));

    always #5 aclk = ~aclk;

    // watchdog, adc pulse count, lsw-to-msw carry seen on the time base
    always @(posedge aclk) begin
        cyc++;
        if (adc_trigger === 1'b1) n_adc++;
        if (upper_time_base === 16'h0001 && lower_time_base === 16'h0000) carry = 1'b1;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done;
        end
    end

    task automatic test_done;
        $display("counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
            n_mismatch++;
        end
    endtask

    // bready and rready stay high, so each task only drops its own valids
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        br = s_axi_bresp;
    endtask

    task automatic rdx(input logic [7:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rdx(a);
        chk(rd, e);
    endtask

    // cycles between two steps of the lower time base
    task automatic tick_len(output int c);
        logic [15:0] v;
        // first pass syncs to a step, second one measures
        repeat (2) begin
            c = 0;
            v = lower_time_base;
            while (lower_time_base === v && c < 600) begin
                @(posedge aclk);
                c++;
            end
        end
    endtask

    task automatic wait_irq;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
    endtask

    initial begin
        aclk = 0; aresetn = 0; ce = 1; idle_mode = 0; lower_clk_pin = 0; lower_gate_pin = 0; carry = 0;
        s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_arvalid = 0; s_axi_bready = 1; s_axi_rready = 1;
        s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF;
        n_mismatch = 0; n_compared = 0; cyc = 0; n_adc = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, unmapped place, writable control bits
        rdc(ADDR_LOWER_CTRL, 32'h0);
        rdc(ADDR_UPPER_CTRL, 32'h0);
        rdc(ADDR_LOWER_PERIOD, 32'h0000FFFF);
        rdc(ADDR_UPPER_PERIOD, 32'h0000FFFF);
        rdc(ADDR_UPPER_COUNT, 32'h0);
        rdc(ADDR_IRQ_STATUS, 32'h0);
        rdx(8'h24);
        chk(32'(rr), 32'(AXI_SLVERR));
        wr(8'h24, 32'h0);
        chk(32'(br), 32'(AXI_SLVERR));
        wr(ADDR_LOWER_CTRL, 32'hFFFFFFFF);
        chk(32'(br), 32'(AXI_OKAY));
        rdc(ADDR_LOWER_CTRL, {16'h0000, CTRL_WMASK});
        wr(ADDR_LOWER_CTRL, 32'h0);
        $display("test 1 done");
        // every prescale ratio, measured on the time base
        for (i = 0; i < 4; i++) begin
            wr(ADDR_LOWER_COUNT, 32'h0);
            wr(ADDR_LOWER_CTRL, 32'h8000 | (32'(i) << 4));
            tick_len(n);
            chk(32'(n), 32'(pre_t[i]) + 32'h1);
            wr(ADDR_LOWER_CTRL, 32'h0);
        end
        $display("test 2 done");
        // 16-bit match, mask, priority, clear by one
        wr(ADDR_LOWER_PERIOD, 32'h3);
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(ADDR_IRQ_PRIO, 32'h53);
        wr(ADDR_LOWER_CTRL, 32'h8000);
        wait_irq;
        wr(ADDR_LOWER_CTRL, 32'h0);
        rdc(ADDR_IRQ_STATUS, 32'h1);
        chk(32'(irq_priority), 32'h3);
        chk(32'(n_adc), 32'h0);
        wr(ADDR_IRQ_MASK, 32'h0);
        chk(32'(irq), 32'h0);
        wr(ADDR_IRQ_MASK, 32'h1);
        chk(32'(irq), 32'h1);
        wr(ADDR_IRQ_STATUS, 32'h1);
        chk(32'(irq), 32'h0);
        // upper timer on its own: own flag, own priority, no adc pulse
        wr(ADDR_UPPER_PERIOD, 32'h3);
        wr(ADDR_IRQ_MASK, 32'h2);
        wr(ADDR_UPPER_CTRL, 32'h8000);
        wait_irq;
        wr(ADDR_UPPER_CTRL, 32'h0);
        rdc(ADDR_IRQ_STATUS, 32'h2);
        chk(32'(irq_priority), 32'h5);
        chk(32'(n_adc), 32'h0);
        wr(ADDR_IRQ_STATUS, 32'h2);
        $display("test 3 done");
        // idle: runs unless told to stop in idle
        idle_mode <= 1'b1;
        wr(ADDR_LOWER_PERIOD, 32'hFFFF);
        wr(ADDR_LOWER_CTRL, 32'h8000);
        tick_len(n);
        chk(32'(n), 32'h1);
        // clock enable low: the running count must not move
        ce <= 1'b0;
        @(posedge aclk);
        c0 = {16'h0000, lower_time_base};
        repeat (10) @(posedge aclk);
        chk({16'h0000, lower_time_base}, c0);
        ce <= 1'b1;
        wr(ADDR_LOWER_CTRL, 32'hA000);
        rdx(ADDR_LOWER_COUNT);
        c0 = rd;
        rdc(ADDR_LOWER_COUNT, c0);
        idle_mode <= 1'b0;
        $display("test 4 done");
        // external clock edges, then gated accumulation
        wr(ADDR_LOWER_CTRL, 32'h8002);
        wr(ADDR_LOWER_COUNT, 32'h0);
        for (i = 0; i < 5; i++) begin
            lower_clk_pin <= 1'b1;
            repeat (3) @(posedge aclk);
            lower_clk_pin <= 1'b0;
            repeat (3) @(posedge aclk);
        end
        rdc(ADDR_LOWER_COUNT, 32'h5);
        wr(ADDR_LOWER_CTRL, 32'h8040);
        wr(ADDR_LOWER_COUNT, 32'h0);
        repeat (20) @(posedge aclk);
        rdc(ADDR_LOWER_COUNT, 32'h0);
        lower_gate_pin <= 1'b1;
        repeat (20) @(posedge aclk);
        lower_gate_pin <= 1'b0;
        repeat (6) @(posedge aclk);
        rdx(ADDR_LOWER_COUNT);
        // both gate edges see the same sync delay, so 20 clocks exactly
        chk(rd, 32'd20);
        wr(ADDR_LOWER_CTRL, 32'h0);
        $display("test 5 done");
        // cascade set first; upper control set slow on purpose, must be ignored
        wr(ADDR_LOWER_CTRL, 32'h0008);
        wr(ADDR_UPPER_CTRL, 32'h8030);
        wr(ADDR_LOWER_COUNT, 32'hFFF0);
        wr(ADDR_UPPER_COUNT, 32'h0);
        wr(ADDR_LOWER_PERIOD, 32'h2);
        wr(ADDR_UPPER_PERIOD, 32'h1);
        wr(ADDR_IRQ_MASK, 32'h3);
        carry = 1'b0;
        wr(ADDR_LOWER_CTRL, 32'h8008);
        wait_irq;
        repeat (3) @(posedge aclk);
        wr(ADDR_LOWER_CTRL, 32'h0);
        chk(32'(carry), 32'h1);
        rdc(ADDR_IRQ_STATUS, 32'h2);
        chk(32'(irq_priority), 32'h5);
        chk(32'(n_adc), 32'h1);
        $display("test 6 done");
        test_done;
    end
endmodule
`default_nettype wire
